/* power_on_reset_sequencer.sv */
// power-on reset sequencer: watchdog clock select, reset sync, port defaults
// Operation
// R1: external reset is active high, held at least twelve oscillator periods.
// R2: internal reset done in second machine cycle, repeated until input low.
// R3: strobe pins become inputs during reset; outside must not drive them.
// R4: execution begins at program address 0000 hex after reset.
// R5: reset loads FF into latches of ports 0 to 4.
// R6: reset does not touch internal RAM or extended RAM contents.
// R7: RC faster than main oscillator means failure; chip runs from RC.
// R8: after main oscillator runs, hold reset 768 RC cycles, then switch.
// R9: external reset still held keeps device in reset after watchdog release.
// R10: external reset ends power-down and clears watchdog status flag; code clears the flag only once the watchdog has released and oscFail is low.
// R11: with crystal, hold reset until stabilisation ends plus two cycles.
// R12: with external clock generator, about 1 ms external reset suffices.
// R13: reset input sampled once per machine cycle in state 5 phase 2.
// R14: internal reset procedure spans two complete machine cycles.
// R15: device stays in reset while input stays asserted.
// R16: release seen at S5P2 sample, run at next S5P1, strobe one phase later.
// R17: machine cycle is six states of two phases, twelve oscillator periods.
module power_on_reset_sequencer (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic resetPin,
	input wire logic rcTick,
	input wire logic mainOscTick,
	input wire logic powerDown,
	output logic coreReset_r,
	output logic running_r,
	output logic useRcClock_r,
	output logic osc_watchdog_status_flag_r,
	output logic powerDownExit_r,
	output logic [15:0] fetchAddr_r,
	output logic [39:0] portLatch_r,
	output logic ramWriteBlock_r,
	output logic addrLatchStrobe_r,
	output logic addrLatchStrobeOe_r,
	output logic program_store_strobe_n_r,
	output logic program_store_strobe_n_oe_r
);
	////////////////////////////////////////////////////////////////////
	// input synchronisers, three stages, change when stages two and three agree
	logic [2:0] rstSync_r, rcSync_r, mainSync_r;
	logic resetLvl_r, rcLvl_r, mainLvl_r;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rstSync_r <= 3'h7; // agrees with resetLvl_r, no false low after reset
			rcSync_r <= 3'h0;
			mainSync_r <= 3'h0;
		end else begin
			rstSync_r <= {rstSync_r[1:0], resetPin};
			rcSync_r <= {rcSync_r[1:0], rcTick};
			mainSync_r <= {mainSync_r[1:0], mainOscTick};
		end
	end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			resetLvl_r <= 1'b1;
			rcLvl_r <= 1'b0;
			mainLvl_r <= 1'b0;
		end else begin
			if (rstSync_r[1] == rstSync_r[2]) resetLvl_r <= rstSync_r[2];
			if (rcSync_r[1] == rcSync_r[2]) rcLvl_r <= rcSync_r[2];
			if (mainSync_r[1] == mainSync_r[2]) mainLvl_r <= mainSync_r[2];
		end
	end
	logic rcPrev_r, mainPrev_r;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rcPrev_r <= 1'b0;
			mainPrev_r <= 1'b0;
		end else begin
			rcPrev_r <= rcLvl_r;
			mainPrev_r <= mainLvl_r;
		end
	end
	logic rcEdge, mainEdge;
	assign rcEdge = rcLvl_r & ~rcPrev_r;
	assign mainEdge = mainLvl_r & ~mainPrev_r;

	////////////////////////////////////////////////////////////////////
	// oscillator watchdog: count RC edges between main edges
	por_seq_pkg::owd_state_t owdState_r;
	logic [3:0] rcSinceMain_r;
	logic [9:0] stabCnt_r;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rcSinceMain_r <= 4'h0;
		end else if (mainEdge) begin
			rcSinceMain_r <= 4'h0;
		end else if (rcEdge && rcSinceMain_r != 4'hF) begin
			rcSinceMain_r <= rcSinceMain_r + 4'h1;
		end
	end
	logic oscFail;
	// rc outruns main when several rc edges pass without a main edge
	assign oscFail = (rcSinceMain_r >= por_seq_pkg::FAIL_LIMIT); // R7
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			owdState_r <= por_seq_pkg::OWD_FAIL;
			stabCnt_r <= 10'h000;
		end else begin
			unique case (owdState_r)
				por_seq_pkg::OWD_FAIL: begin
					stabCnt_r <= 10'h000;
					if (!oscFail && mainEdge) owdState_r <= por_seq_pkg::OWD_STAB;
				end
				por_seq_pkg::OWD_STAB: begin
					if (oscFail) begin
						owdState_r <= por_seq_pkg::OWD_FAIL;
					end else if (rcEdge) begin
						if (stabCnt_r == por_seq_pkg::STAB_RC_CYCLES - 10'h001) begin
							owdState_r <= por_seq_pkg::OWD_DONE; // R8
						end
						stabCnt_r <= stabCnt_r + 10'h001;
					end
				end
				por_seq_pkg::OWD_DONE: begin
					if (oscFail) owdState_r <= por_seq_pkg::OWD_FAIL; // R7
				end
			endcase
		end
	end
	logic owdReset;
	assign owdReset = (owdState_r != por_seq_pkg::OWD_DONE);
	// clock source: RC until the stabilisation phase ends
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			useRcClock_r <= 1'b1;
		end else begin
			useRcClock_r <= owdReset; // R7 R8
		end
	end

	////////////////////////////////////////////////////////////////////
	// machine cycle timing
	logic [3:0] slot;
	logic cycleEnd;
	phase_gen u_phase (
		.clk(clk_sys),
		.rst(rst),
		.slot_r(slot),
		.cycleEnd_r(cycleEnd)
	); // R17
	logic sampleNow, startNow;
	assign sampleNow = (slot == por_seq_pkg::SAMPLE_SLOT);
	assign startNow = (slot == por_seq_pkg::START_SLOT);

	////////////////////////////////////////////////////////////////////
	// reset sample once per cycle and two-cycle internal reset
	logic sampledHigh_r;
	logic [1:0] resetCycles_r;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sampledHigh_r <= 1'b1;
		end else if (sampleNow) begin
			sampledHigh_r <= resetLvl_r | owdReset; // R13 R9
		end
	end
	// count machine cycles in reset; once started the procedure runs two full ones,
	// cleared while running so a later reset cannot reuse an old count
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			resetCycles_r <= 2'h0;
		end else if (sampleNow && (resetLvl_r | owdReset | coreReset_r)) begin
			if (resetCycles_r != 2'(por_seq_pkg::INT_RESET_CYCLES)) begin
				resetCycles_r <= resetCycles_r + 2'h1; // R14
			end
		end else if (running_r) begin
			resetCycles_r <= 2'h0; // R14
		end
	end
	logic inReset;
	assign inReset = sampledHigh_r | ~running_r;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			coreReset_r <= 1'b1;
			running_r <= 1'b0;
		end else begin
			if (sampledHigh_r) begin
				coreReset_r <= 1'b1; // R2 R15
				running_r <= 1'b0;
			end else if (startNow && coreReset_r &&
				resetCycles_r == 2'(por_seq_pkg::INT_RESET_CYCLES)) begin
				coreReset_r <= 1'b0; // R16
				running_r <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// default state loaded every cycle while held in reset
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			portLatch_r <= {por_seq_pkg::NUM_PORTS{por_seq_pkg::PORT_RESET}};
			fetchAddr_r <= por_seq_pkg::START_ADDR;
		end else if (coreReset_r) begin
			portLatch_r <= {por_seq_pkg::NUM_PORTS{por_seq_pkg::PORT_RESET}}; // R5
			fetchAddr_r <= por_seq_pkg::START_ADDR; // R4
		end
	end
	// ram is never cleared; only writes are blocked while in reset
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ramWriteBlock_r <= 1'b1;
		end else begin
			ramWriteBlock_r <= inReset; // R6
		end
	end

	////////////////////////////////////////////////////////////////////
	// strobe pins: released as inputs during reset, address latch strobe first falls at S5P2, program store strobe stays high
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			addrLatchStrobeOe_r <= 1'b0;
			program_store_strobe_n_oe_r <= 1'b0;
			addrLatchStrobe_r <= 1'b1;
			program_store_strobe_n_r <= 1'b1;
		end else begin
			addrLatchStrobeOe_r <= running_r & ~sampledHigh_r; // R3
			program_store_strobe_n_oe_r <= running_r & ~sampledHigh_r; // R3
			program_store_strobe_n_r <= 1'b1;
			if (!running_r) begin
				addrLatchStrobe_r <= 1'b1;
			end else if (slot == por_seq_pkg::STROBE_SLOT) begin
				addrLatchStrobe_r <= 1'b0; // R16
			end else if (slot == 4'h3) begin
				addrLatchStrobe_r <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// watchdog status flag and power-down exit
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			osc_watchdog_status_flag_r <= 1'b0;
			powerDownExit_r <= 1'b0;
		end else begin
			powerDownExit_r <= powerDown & resetLvl_r; // R10
			if (oscFail) begin
				osc_watchdog_status_flag_r <= 1'b1; // set wins over clear
			end else if (resetLvl_r && !owdReset) begin
				osc_watchdog_status_flag_r <= 1'b0; // R10
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks
	a_port_defaults: assert property (@(posedge clk_sys) disable iff (rst) // R5
		coreReset_r |=> portLatch_r == {5{8'hFF}}) else $error("port latch not FF");
	a_start_address: assert property (@(posedge clk_sys) disable iff (rst) // R4
		$fell(coreReset_r) |-> fetchAddr_r == 16'h0000) else $error("bad start addr");
	a_strobe_input: assert property (@(posedge clk_sys) disable iff (rst) // R3
		coreReset_r |=> !program_store_strobe_n_oe_r) else $error("strobe driven");
	a_hold_reset: assert property (@(posedge clk_sys) disable iff (rst) // R15
		sampledHigh_r |=> coreReset_r) else $error("left reset early");
	a_owd_hold: assert property (@(posedge clk_sys) disable iff (rst) // R9
		owdReset && sampleNow |=> ##1 coreReset_r) else $error("ran under owd");
	a_sample_slot: assert property (@(posedge clk_sys) disable iff (rst) // R13
		$changed(sampledHigh_r) |-> $past(slot) == 4'h9) else $error("off sample");
	a_release_slot: assert property (@(posedge clk_sys) disable iff (rst) // R16
		$fell(coreReset_r) |-> slot == 4'h9) else $error("off release");
	a_strobe_fall: assert property (@(posedge clk_sys) disable iff (rst) // R16
		$rose(running_r) |-> ##1 !addrLatchStrobe_r) else $error("no strobe");
	a_rc_select: assert property (@(posedge clk_sys) disable iff (rst) // R7
		oscFail |=> ##1 useRcClock_r) else $error("rc not used");
	a_stab_count: assert property (@(posedge clk_sys) disable iff (rst) // R8
		owdState_r == por_seq_pkg::OWD_STAB |-> stabCnt_r < 10'h300) else $error("stab");
	a_cycle_end: assert property (@(posedge clk_sys) disable iff (rst) // R17
		cycleEnd == (slot == 4'hB)) else $error("cycle end not at last slot");
endmodule

/* por_seq_pkg.sv */
// constants and types shared by the power-on reset sequencer
package por_seq_pkg;
	localparam int OSC_PER_PHASE = 1;
	localparam int PHASES_PER_STATE = 2;
	localparam int STATES_PER_CYCLE = 6;
	localparam int PHASE_CNT = PHASES_PER_STATE * STATES_PER_CYCLE;
	localparam logic [3:0] SAMPLE_SLOT = 4'h9;
	localparam logic [3:0] START_SLOT = 4'h8;
	localparam logic [3:0] STROBE_SLOT = 4'h9;
	localparam logic [9:0] STAB_RC_CYCLES = 10'h300;
	localparam logic [15:0] START_ADDR = 16'h0000;
	localparam logic [7:0] PORT_RESET = 8'hFF;
	localparam int NUM_PORTS = 5;
	localparam int INT_RESET_CYCLES = 2;
	localparam logic [3:0] FAIL_LIMIT = 4'h4;
	typedef enum logic [1:0] {
		OWD_FAIL,
		OWD_STAB,
		OWD_DONE
	} owd_state_t;
endpackage

/* phase_gen.sv */
// twelve-phase machine-cycle slot counter
module phase_gen (
	input wire logic clk,
	input wire logic rst,
	output logic [3:0] slot_r,
	output logic cycleEnd_r
);
	// six states of two phases each
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			slot_r <= 4'h0;
		end else if (slot_r == 4'(por_seq_pkg::PHASE_CNT - 1)) begin
			slot_r <= 4'h0;
		end else begin
			slot_r <= slot_r + 4'h1;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cycleEnd_r <= 1'b0;
		end else begin
			cycleEnd_r <= (slot_r == 4'(por_seq_pkg::PHASE_CNT - 2));
		end
	end
endmodule

/* osc_reset_model.sv */
// far-side model: external reset source, RC oscillator and crystal
module osc_reset_model (
	input wire logic clk_sys,
	input wire logic mainOn,
	input wire logic pinReq,
	output logic rcTick,
	output logic mainOscTick,
	output logic resetPin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] rcCnt;
	logic mainCnt;
	initial begin
		rcCnt = 2'h0;
		mainCnt = 1'b0;
		rcTick = 1'b0;
		mainOscTick = 1'b0;
		resetPin = 1'b1;
	end
	////////////////////////////////////////////////////////////////////////////////
	// rc runs from power-on, one rising edge every eight clocks
	always @(posedge clk_sys) begin
		rcCnt <= rcCnt + 2'h1;
		if (rcCnt == 2'h3) begin
			rcTick <= ~rcTick;
		end
	end
	// crystal stands still until it has started, then outruns the rc
	always @(posedge clk_sys) begin
		mainCnt <= ~mainCnt;
		if (mainOn && mainCnt) begin
			mainOscTick <= ~mainOscTick;
		end
	end
	// reset level is active high; strobe pins are never driven here
	always @(posedge clk_sys) begin
		resetPin <= pinReq;
	end
endmodule

/* tb.sv */
// self-checking bench for the power-on reset sequencer
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin fails++; \
	$display("Error %s expected %0h seen %0h", n, e, a); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {int hold; logic pd;} row_t;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic mainOn = 1'b0;
	logic pinReq = 1'b1;
	logic powerDown = 1'b0;
	logic resetPin, rcTick, mainOscTick, coreReset_r, running_r, useRcClock_r, flag, pdExit;
	logic ramWriteBlock_r, ale, aleOe, pse, pseOe;
	logic [15:0] fetchAddr_r;
	logic [39:0] portLatch_r;
	int fails = 0;
	int checks = 0;
	int n;
	// hold lengths allow for the three-flop sync plus the slot wait
	row_t rows[3] = '{'{24, 1'b0}, '{30, 1'b1}, '{40, 1'b0}};
	always #10 clk_sys = ~clk_sys;
	////////////////////////////////////////////////////////////////////////////////
	osc_reset_model i_far (.clk_sys(clk_sys), .mainOn(mainOn), .pinReq(pinReq),
		.rcTick(rcTick), .mainOscTick(mainOscTick), .resetPin(resetPin));
	power_on_reset_sequencer i_dut (.clk_sys(clk_sys), .rst(rst), .resetPin(resetPin),
		.rcTick(rcTick), .mainOscTick(mainOscTick), .powerDown(powerDown),
		.coreReset_r(coreReset_r), .running_r(running_r), .useRcClock_r(useRcClock_r),
		.osc_watchdog_status_flag_r(flag), .powerDownExit_r(pdExit),
		.fetchAddr_r(fetchAddr_r), .portLatch_r(portLatch_r),
		.ramWriteBlock_r(ramWriteBlock_r), .addrLatchStrobe_r(ale),
		.addrLatchStrobeOe_r(aleOe), .program_store_strobe_n_r(pse),
		.program_store_strobe_n_oe_r(pseOe));
	////////////////////////////////////////////////////////////////////////////////
	// sample one step after the edge so its updates have landed
	task automatic tick(input int k);
		repeat (k) begin
			@(posedge clk_sys);
			#1;
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic reset_state();
		`CHK("coreReset", 1'b1, coreReset_r)
		`CHK("running", 1'b0, running_r)
		`CHK("ports", {5{8'hFF}}, portLatch_r)
		`CHK("aleOe", 1'b0, aleOe)
		`CHK("pseOe", 1'b0, pseOe)
		`CHK("ramBlock", 1'b1, ramWriteBlock_r)
	endtask
	task automatic release_check();
		int k;
		@(posedge clk_sys) begin
			pinReq <= 1'b0;
			powerDown <= 1'b0;
		end
		for (k = 0; k < 100 && running_r !== 1'b1; k++) tick(1);
		`CHK("running", 1'b1, running_r)
		`CHK("coreReset", 1'b0, coreReset_r)
		`CHK("fetchAddr", 16'h0000, fetchAddr_r)
		tick(1);
		`CHK("ramBlock", 1'b0, ramWriteBlock_r)
		`CHK("aleFall", 1'b0, ale)
		`CHK("aleOe", 1'b1, aleOe)
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// power-up under the rc clock, stabilisation, then the pulse table
	initial begin
		tick(16);
		reset_state();
		`CHK("flagRst", 1'b0, flag)
		@(posedge clk_sys) rst <= 1'b0;
		tick(100);
		`CHK("flagFail", 1'b1, flag)
		`CHK("useRc", 1'b1, useRcClock_r)
		reset_state();
		@(posedge clk_sys) mainOn <= 1'b1;
		for (n = 0; n < 8000 && useRcClock_r !== 1'b0; n++) tick(1);
		`CHK("stabLen", 1'b1, n > 6100 && n < 6200)
		`CHK("heldByPin", 1'b1, coreReset_r)
		tick(24);
		release_check();
		`CHK("flagClr", 1'b0, flag)
		$display("test powerup done");
		foreach (rows[i]) begin
			@(posedge clk_sys) begin
				pinReq <= 1'b1;
				powerDown <= rows[i].pd;
			end
			tick(rows[i].hold);
			reset_state();
			`CHK("pdExit", rows[i].pd, pdExit)
			release_check();
			$display("test pulse %0d done", i);
		end
		// second power-on reset in mid-run falls back to the rc clock
		@(posedge clk_sys) rst <= 1'b1;
		tick(2);
		reset_state();
		`CHK("useRcAgain", 1'b1, useRcClock_r)
		// release again: watchdog restarts its hold while the crystal keeps running
		@(posedge clk_sys) rst <= 1'b0;
		tick(2);
		`CHK("heldAfterRst", 1'b1, coreReset_r)
		`CHK("rcAfterRst", 1'b1, useRcClock_r)
		`CHK("flagAfterRst", 1'b0, flag)
		$display("test midrun done");
		report_and_stop();
	end
	// hang guard, generous against the roughly 7000 cycles needed
	initial begin
		#(20 * 20000);
		fails++;
		report_and_stop();
	end
endmodule
